/* File: rtl/dacsw_pkg.sv */
// Shared constants and types for the serial write front end
package dacsw_pkg;

	// ==========================================================
	// Frame layout
	localparam int unsigned WORD_BITS  = 24;
	localparam int unsigned DATA_BITS  = 16;
	localparam int unsigned CHANNELS   = 4;
	localparam int unsigned ENTRY_BITS = DATA_BITS + 1;
	localparam int unsigned CNT_BITS   = 5;

	localparam logic [CNT_BITS-1:0] LAST_BIT_COUNT = 5'h18;
	localparam logic [CNT_BITS-1:0] COUNT_RESET    = 5'h00;

	// Field positions inside the locked word
	localparam int unsigned ADDR_HI_POS = 23;
	localparam int unsigned ADDR_LO_POS = 22;
	localparam int unsigned LOAD_HI_POS = 21;
	localparam int unsigned LOAD_LO_POS = 20;
	localparam int unsigned CHSEL_HI    = 18;
	localparam int unsigned CHSEL_LO    = 17;
	localparam int unsigned PDFLAG_POS  = 16;

	// ==========================================================
	// Load commands
	localparam logic [1:0] LOAD_STORE     = 2'h0;
	localparam logic [1:0] LOAD_SINGLE    = 2'h1;
	localparam logic [1:0] LOAD_SIMUL     = 2'h2;
	localparam logic [1:0] LOAD_BROADCAST = 2'h3;

	// ==========================================================
	// Reset values: zero scale, powered up
	localparam logic [WORD_BITS-1:0]  WORD_RESET  = 24'h000000;
	localparam logic [ENTRY_BITS-1:0] ENTRY_RESET = 17'h00000;
	localparam logic [1:0]            SYNC_RESET  = 2'h3;

	typedef enum logic [1:0] {
		DACSW_IDLE,
		DACSW_SHIFT,
		DACSW_LOCKED
	} dacsw_state_t;

	typedef logic [ENTRY_BITS-1:0] dacsw_entry_t;

endpackage : dacsw_pkg

/* File: rtl/dacsw_word_if.sv */
// Carrier for a locked frame from the shifter to the decoder
`timescale 1ns/1ps
interface dacsw_word_if;
	import dacsw_pkg::*;

	logic                 word_valid;
	logic [WORD_BITS-1:0] word;
	logic [1:0]           strap;

	modport sender
	(
		output word_valid,
		output word,
		output strap
	);

	modport receiver
	(
		input word_valid,
		input word,
		input strap
	);
endinterface : dacsw_word_if

/* File: rtl/dacsw_decode.sv */
// Command decoder with temporary and channel registers
`timescale 1ns/1ps
module dacsw_decode
	import dacsw_pkg::*;
(
	input  wire logic                                clock,
	input  wire logic                                nrst,
	dacsw_word_if.receiver                           frame,
	output logic [CHANNELS-1:0][ENTRY_BITS-1:0]      buffer_entry,
	output logic [CHANNELS-1:0][ENTRY_BITS-1:0]      channel_entry,
	output logic                                     update_done
);

	// ==========================================================
	// Field helpers
	function automatic logic chan_hit(input logic [WORD_BITS-1:0] w,
		input int unsigned ch);
		chan_hit = (w[CHSEL_HI:CHSEL_LO] == ch[1:0]);
	endfunction : chan_hit

	logic [1:0]   load_cmd;
	logic         addressed;
	dacsw_entry_t new_entry;

	always_comb
	begin
		load_cmd  = frame.word[LOAD_HI_POS:LOAD_LO_POS];
		// Data and powerdown_flag travel together; mode bits stay in data
		new_entry = frame.word[PDFLAG_POS:0];
		addressed = (frame.word[ADDR_HI_POS:ADDR_LO_POS] == frame.strap)
			|| (load_cmd == LOAD_BROADCAST);
	end

	// ==========================================================
	// Per-channel update
	genvar gi;
	generate
		for (gi = 0; gi < CHANNELS; gi++)
		begin : g_chan
			dacsw_entry_t buf_q;
			dacsw_entry_t buf_d;
			dacsw_entry_t dac_q;
			dacsw_entry_t dac_d;
			logic         hit;

			always_comb
			begin
				hit   = chan_hit(frame.word, gi);
				buf_d = buf_q;
				dac_d = dac_q;
				// Unaddressed or aborted frames leave everything as is
				if (frame.word_valid && addressed)
				begin
					case (load_cmd)
						LOAD_STORE:
						begin
							if (hit)
								buf_d = new_entry;
						end
						LOAD_SINGLE:
						begin
							if (hit)
							begin
								buf_d = new_entry;
								dac_d = new_entry;
							end
						end
						LOAD_SIMUL:
						begin
							if (hit)
							begin
								buf_d = new_entry;
								dac_d = new_entry;
							end
							else
								dac_d = buf_q;
						end
						LOAD_BROADCAST:
						begin
							if (frame.word[CHSEL_HI])
							begin
								buf_d = new_entry;
								dac_d = new_entry;
							end
							else
								dac_d = buf_q;
						end
						default:
						begin
							buf_d = buf_q;
						end
					endcase
				end
			end

			always_ff @(posedge clock or negedge nrst)
			begin
				if (!nrst)
				begin
					buf_q <= ENTRY_RESET;
					dac_q <= ENTRY_RESET;
				end
				else
				begin
					buf_q <= buf_d;
					dac_q <= dac_d;
				end
			end

			assign buffer_entry[gi]  = buf_q;
			assign channel_entry[gi] = dac_q;
		end
	endgenerate

	// ==========================================================
	// Completion pulse
	logic next_update_done;

	always_comb
	begin
		next_update_done = frame.word_valid && addressed;
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			update_done <= 1'b0;
		else
			update_done <= next_update_done;
	end

endmodule : dacsw_decode

/* File: rtl/dacsw_frontend.sv */
// Serial write front end: pin sampling, shifter and decoder
`timescale 1ns/1ps
module dacsw_frontend
	import dacsw_pkg::*;
(
	input  wire logic                           clock,
	input  wire logic                           nrst,
	input  wire logic                           frame_select_n,
	input  wire logic                           serial_clock,
	input  wire logic                           serial_data,
	input  wire logic                           port_enable_n,
	input  wire logic                           address_strap_high,
	input  wire logic                           address_strap_low,
	output logic [CHANNELS-1:0][ENTRY_BITS-1:0] buffer_entry,
	output logic [CHANNELS-1:0][ENTRY_BITS-1:0] channel_entry,
	output logic                                update_done,
	output logic                                frame_aborted
);

	// ==========================================================
	// Pin synchronisers
	// Link clock is only sampled; 80 ns period gives 8 samples per bit
	logic [1:0] sel_sync;
	logic [1:0] clk_sync;
	logic [1:0] dat_sync;
	logic [1:0] en_sync;
	logic [1:0] strap_hi_sync;
	logic [1:0] strap_lo_sync;
	logic       clk_prev;
	logic       sel_prev;
	logic [1:0] next_sel_sync;
	logic [1:0] next_clk_sync;
	logic [1:0] next_dat_sync;
	logic [1:0] next_en_sync;
	logic [1:0] next_strap_hi_sync;
	logic [1:0] next_strap_lo_sync;
	logic       next_clk_prev;
	logic       next_sel_prev;

	always_comb
	begin
		// Straps are resampled all the time; a change acts on the next word to lock
		next_sel_sync      = {sel_sync[0], frame_select_n};
		next_clk_sync      = {clk_sync[0], serial_clock};
		next_dat_sync      = {dat_sync[0], serial_data};
		next_en_sync       = {en_sync[0], port_enable_n};
		next_strap_hi_sync = {strap_hi_sync[0], address_strap_high};
		next_strap_lo_sync = {strap_lo_sync[0], address_strap_low};
		next_clk_prev      = clk_sync[1];
		next_sel_prev      = sel_sync[1];
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			// Idle high levels, so no false edge follows reset
			sel_sync      <= SYNC_RESET;
			clk_sync      <= SYNC_RESET;
			dat_sync      <= 2'h0;
			en_sync       <= SYNC_RESET;
			strap_hi_sync <= 2'h0;
			strap_lo_sync <= 2'h0;
			clk_prev      <= 1'b1;
			sel_prev      <= 1'b1;
		end
		else
		begin
			sel_sync      <= next_sel_sync;
			clk_sync      <= next_clk_sync;
			dat_sync      <= next_dat_sync;
			en_sync       <= next_en_sync;
			strap_hi_sync <= next_strap_hi_sync;
			strap_lo_sync <= next_strap_lo_sync;
			clk_prev      <= next_clk_prev;
			sel_prev      <= next_sel_prev;
		end
	end

	// Falling-edge decode shared by link clock and frame select
	function automatic logic fell(input logic prev_level,
		input logic cur_level);
		fell = prev_level && !cur_level;
	endfunction : fell

	logic sclk_fall;
	logic sel_fall;
	logic sel_rise;
	logic port_on;

	always_comb
	begin
		sclk_fall = fell(clk_prev, clk_sync[1]);
		sel_fall  = fell(sel_prev, sel_sync[1]);
		sel_rise  = !sel_prev && sel_sync[1];
		port_on   = !en_sync[1];
	end

	// ==========================================================
	// Frame state machine and shifter
	dacsw_state_t         state;
	dacsw_state_t         next_state;
	logic [WORD_BITS-1:0] shift;
	logic [WORD_BITS-1:0] next_shift;
	logic [CNT_BITS-1:0]  count;
	logic [CNT_BITS-1:0]  next_count;
	logic                 word_valid;
	logic                 next_word_valid;
	logic                 next_frame_aborted;

	always_comb
	begin
		next_state         = state;
		next_shift         = shift;
		next_count         = count;
		next_word_valid    = 1'b0;
		next_frame_aborted = 1'b0;
		if (!port_on)
		begin
			// Disabled port drops any frame in progress
			next_state = DACSW_IDLE;
			next_count = COUNT_RESET;
		end
		else if (sel_fall)
		begin
			next_state = DACSW_SHIFT;
			next_count = COUNT_RESET;
		end
		else
		begin
			case (state)
				DACSW_IDLE:
				begin
					next_state = DACSW_IDLE;
				end
				DACSW_SHIFT:
				begin
					if (sel_rise)
					begin
						// Partial word never reaches the decoder
						next_state         = DACSW_IDLE;
						next_count         = COUNT_RESET;
						next_frame_aborted = 1'b1;
					end
					else if (sclk_fall && !sel_sync[1])
					begin
						next_shift = {shift[WORD_BITS-2:0], dat_sync[1]};
						next_count = count + 5'h01;
						if (count + 5'h01 == LAST_BIT_COUNT)
						begin
							next_state      = DACSW_LOCKED;
							next_word_valid = 1'b1;
						end
					end
				end
				DACSW_LOCKED:
				begin
					// Further clocks ignored until the next select fall
					next_state = DACSW_LOCKED;
				end
				default:
				begin
					next_state = DACSW_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			state         <= DACSW_IDLE;
			shift         <= WORD_RESET;
			count         <= COUNT_RESET;
			word_valid    <= 1'b0;
			frame_aborted <= 1'b0;
		end
		else
		begin
			state         <= next_state;
			shift         <= next_shift;
			count         <= next_count;
			word_valid    <= next_word_valid;
			frame_aborted <= next_frame_aborted;
		end
	end

	// ==========================================================
	// Decoder
	dacsw_word_if word_link ();

	assign word_link.word_valid = word_valid;
	assign word_link.word       = shift;
	assign word_link.strap      = {strap_hi_sync[1], strap_lo_sync[1]};

	dacsw_decode u_decode
	(
		.clock         (clock),
		.nrst          (nrst),
		.frame         (word_link.receiver),
		.buffer_entry  (buffer_entry),
		.channel_entry (channel_entry),
		.update_done   (update_done)
	);

endmodule : dacsw_frontend

/* File: tb/dacsw_host.sv */
// Host serial master model driving the write front end pins
`timescale 1ns/1ps
module dacsw_host
(
	input  wire logic clock,
	output logic      frame_select_n,
	output logic      serial_clock,
	output logic      serial_data
);
	// ==========================================================
	// Frame driver; the link clock idles high between frames
	initial {frame_select_n, serial_clock, serial_data} = 3'h7;

	task automatic frame(input logic [23:0] w, input int n, input int extra,
		input logic close);
		@(posedge clock);
		#3;
		if (!frame_select_n)
		begin
			frame_select_n = 1'b1;
			#50;
		end
		frame_select_n = 1'b0;
		for (int i = 0; i < n + extra; i++)
		begin
			serial_data = (i < n) ? w[23 - i] : i[0];
			#40 serial_clock = 1'b0;
			#40 serial_clock = 1'b1;
		end
		// Released data line shows the inverse, never a held value
		serial_data = ~serial_data;
		#140 frame_select_n = close;
		#100;
	endtask : frame
endmodule : dacsw_host

/* File: tb/dacsw_frontend_props.sv */
// Checker for the serial write front end, bound to its top module
`timescale 1ns/1ps
module dacsw_frontend_props
	import dacsw_pkg::*;
(
	input wire logic                           clock,
	input wire logic                           nrst,
	input wire logic                           frame_select_n,
	input wire logic                           serial_clock,
	input wire logic                           serial_data,
	input wire logic                           port_enable_n,
	input wire logic                           address_strap_high,
	input wire logic                           address_strap_low,
	input wire logic [CHANNELS-1:0][ENTRY_BITS-1:0] buffer_entry,
	input wire logic [CHANNELS-1:0][ENTRY_BITS-1:0] channel_entry,
	input wire logic                           update_done,
	input wire logic                           frame_aborted
);
	// ==========================================================
	// Pin-level copy of the frame, frozen after the last bit
	logic [4:0]  n_fall, next_n_fall;
	logic [23:0] sh, next_sh;
	logic        sel_q, sck_q;

	always_comb
	begin
		{next_n_fall, next_sh} = {n_fall, sh};
		if (sel_q && !frame_select_n)
			next_n_fall = 5'h00;
		else if (!frame_select_n && sck_q && !serial_clock && n_fall < 5'h18)
			{next_n_fall, next_sh} = {n_fall + 5'h01, sh[22:0], serial_data};
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			{sel_q, sck_q, n_fall, sh} <= {2'h3, 5'h00, 24'h000000};
		else
			{sel_q, sck_q, n_fall, sh} <= {frame_select_n, serial_clock,
				next_n_fall, next_sh};
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	sequence s_off;
		port_enable_n [*8];
	endsequence
	property p_hold;
		!update_done |-> $stable(buffer_entry) && $stable(channel_entry);
	endproperty
	property p_pulse;
		update_done |=> !update_done;
	endproperty
	property p_count;
		update_done |-> n_fall == 5'h18;
	endproperty
	property p_word;
		update_done && sh[21:20] == 2'h1 |->
			channel_entry[sh[18:17]] == sh[16:0];
	endproperty
	property p_store;
		update_done && sh[21:20] == 2'h0 |->
			buffer_entry[sh[18:17]] == sh[16:0] && $stable(channel_entry);
	endproperty
	property p_addr;
		update_done |-> sh[21:20] == 2'h3 ||
			sh[23:22] == {address_strap_high, address_strap_low};
	endproperty
	property p_abort;
		frame_aborted |-> n_fall < 5'h18 && !update_done && frame_select_n;
	endproperty
	property p_abpulse;
		frame_aborted |=> !frame_aborted;
	endproperty
	property p_enable;
		s_off |-> !update_done;
	endproperty

	a_hold: assert property (p_hold)
		else $error("entries moved without an update");
	a_pulse: assert property (p_pulse)
		else $error("update pulse longer than one cycle");
	a_count: assert property (p_count)
		else $error("update without exactly 24 clock falls");
	a_word: assert property (p_word)
		else $error("output entry differs from shifted word");
	a_store: assert property (p_store)
		else $error("store command wrong");
	a_addr: assert property (p_addr)
		else $error("update on address mismatch");
	a_abort: assert property (p_abort)
		else $error("abort without an early select rise");
	a_abpulse: assert property (p_abpulse)
		else $error("abort pulse longer than one cycle");
	a_enable: assert property (p_enable)
		else $error("update while port disabled");
endmodule : dacsw_frontend_props

bind dacsw_frontend dacsw_frontend_props u_props (.clock, .nrst,
	.frame_select_n, .serial_clock, .serial_data, .port_enable_n,
	.address_strap_high, .address_strap_low, .buffer_entry,
	.channel_entry, .update_done, .frame_aborted);

/* File: tb/tb_dacsw_frontend.sv */
// Self-checking bench for the serial write front end
`timescale 1ns/1ps
module tb_dacsw_frontend
	import dacsw_pkg::*;
;
	logic clock              = 1'b0;
	logic nrst               = 1'b0;
	logic port_enable_n      = 1'b0;
	logic address_strap_high = 1'b1;
	logic address_strap_low  = 1'b0;
	logic frame_select_n, serial_clock, serial_data;
	logic [CHANNELS-1:0][ENTRY_BITS-1:0] buffer_entry, channel_entry;
	logic update_done, frame_aborted;
	int   n_fail       = 0;
	int   total_checks = 0;
	int   n_upd        = 0;
	int   n_abt        = 0;

	// ==========================================================
	// Clock, pulse counters and instances
	always #5 clock = ~clock;
	// Counted on the falling edge so the pulse has settled
	always @(negedge clock)
	begin
		n_upd += int'(update_done === 1'b1);
		n_abt += int'(frame_aborted === 1'b1);
	end

	dacsw_frontend DUT (.clock, .nrst, .frame_select_n, .serial_clock,
		.serial_data, .port_enable_n, .address_strap_high,
		.address_strap_low, .buffer_entry, .channel_entry, .update_done,
		.frame_aborted);
	dacsw_host host (.clock, .frame_select_n, .serial_clock, .serial_data);

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic chk(input int ch, input logic [16:0] b, input logic [16:0] c);
		check(32'(buffer_entry[ch]), 32'(b));
		check(32'(channel_entry[ch]), 32'(c));
	endtask : chk

	task automatic test_done;
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : test_done

	// ==========================================================
	// Scenarios
	task automatic s_abort;
		host.frame(24'h910000, 12, 0, 1'b1);
		check(n_abt, 32'h1);
		check(n_upd, 32'h0);
		chk(0, 17'h00000, 17'h00000);
	endtask : s_abort

	task automatic s_single;
		host.frame(24'h94FFFF, 24, 0, 1'b1);
		check(n_upd, 32'h1);
		chk(2, 17'h0FFFF, 17'h0FFFF);
	endtask : s_single

	// Extra clocks after the last bit, select left low afterwards
	task automatic s_store;
		host.frame(24'h838001, 24, 2, 1'b0);
		check(n_upd, 32'h2);
		chk(1, 17'h18001, 17'h00000);
	endtask : s_store

	task automatic s_other_addr;
		host.frame(24'h501111, 24, 0, 1'b1);
		check(n_upd, 32'h2);
		chk(0, 17'h00000, 17'h00000);
	endtask : s_other_addr

	task automatic s_disabled;
		@(posedge clock);
		#3 port_enable_n = 1'b1;
		host.frame(24'h901234, 24, 0, 1'b1);
		check(n_upd, 32'h2);
		chk(0, 17'h00000, 17'h00000);
		@(posedge clock);
		#3 port_enable_n = 1'b0;
	endtask : s_disabled

	task automatic s_simul;
		host.frame(24'hA01234, 24, 0, 1'b1);
		check(n_upd, 32'h3);
		chk(0, 17'h01234, 17'h01234);
		chk(1, 17'h18001, 17'h18001);
		chk(2, 17'h0FFFF, 17'h0FFFF);
	endtask : s_simul

	// Broadcast overrides a mismatched address
	task automatic s_bcast;
		host.frame(24'h340555, 24, 0, 1'b1);
		check(n_upd, 32'h4);
		for (int ch = 0; ch < CHANNELS; ch++)
			chk(ch, 17'h00555, 17'h00555);
	endtask : s_bcast

	// Broadcast without new data moves every buffer to its output
	task automatic s_reload;
		host.frame(24'h861111, 24, 0, 1'b1);
		check(n_upd, 32'h5);
		chk(3, 17'h01111, 17'h00555);
		host.frame(24'h30ABCD, 24, 0, 1'b1);
		check(n_upd, 32'h6);
		chk(3, 17'h01111, 17'h01111);
		chk(0, 17'h00555, 17'h00555);
	endtask : s_reload

	initial
	begin
		repeat (12) @(posedge clock);
		#3 nrst = 1'b1;
		repeat (3) @(posedge clock);
		s_abort;
		s_single;
		s_store;
		s_other_addr;
		s_disabled;
		s_simul;
		s_bcast;
		s_reload;
		test_done;
	end

	initial
	begin
		#100000;
		n_fail++;
		test_done;
	end
endmodule : tb_dacsw_frontend
